// >>> shared/lewuw_defines.vh
// Register indices, field positions and reset values for the lookup entry staging words
`ifndef LEWUW_DEFINES_VH
`define LEWUW_DEFINES_VH

// ==========================================================
// Register indices (word address on the management port)
`define LEWUW_IDX_CMD          16'h1800
`define LEWUW_IDX_LOWER        16'h1801
`define LEWUW_IDX_UPPER        16'h1802
`define LEWUW_IDX_CMD_STS      16'h1807

// ==========================================================
// Command and status bits
`define LEWUW_CMD_MAKE_BIT     2
`define LEWUW_STS_PEND_BIT     0

// ==========================================================
// Upper staging word fields
`define LEWUW_F_VALID          26
`define LEWUW_F_AGE            25
`define LEWUW_F_STATIC         24
`define LEWUW_F_FILTER         23
`define LEWUW_F_PRIO_EN        22
`define LEWUW_F_PRIO_HI        21
`define LEWUW_F_PRIO_LO        19
`define LEWUW_F_PORT_HI        18
`define LEWUW_F_PORT_LO        16
`define LEWUW_F_MAC_HI         15
`define LEWUW_F_MAC_LO         0
`define LEWUW_UPPER_WR_MASK    32'h07FFFFFF

// ==========================================================
// Reset values
`define LEWUW_UPPER_RST        32'h00000000
`define LEWUW_LOWER_RST        32'h00000000

`endif

// >>> hdl/lewuw_decode.v
// Field decode of a staged lookup entry into forwarding controls
`timescale 1ns/1ps
`include "lewuw_defines.vh"

module lewuw_decode (
   input  wire [31:0] i_upper,
   input  wire        i_dest_prio_sel,
   output wire [2:0]  o_port_mask,
   output wire        o_port_reserved,
   output wire        o_prio_apply,
   output wire [2:0]  o_prio,
   output wire        o_drop,
   output wire        o_override,
   output wire        o_ageable,
   output wire        o_learn_lock,
   output wire        o_valid
);

   // ==========================================================
   // Port field decode
   function [3:0] lewuw_port_dec;
      input [2:0] code;
      begin
         case (code)
            3'h0:    lewuw_port_dec = 4'h1;
            3'h1:    lewuw_port_dec = 4'h2;
            3'h2:    lewuw_port_dec = 4'h4;
            3'h3:    lewuw_port_dec = 4'h8;
            3'h4:    lewuw_port_dec = 4'h3;
            3'h5:    lewuw_port_dec = 4'h5;
            3'h6:    lewuw_port_dec = 4'h6;
            default: lewuw_port_dec = 4'h7;
         endcase
      end
   endfunction

   wire [3:0] port_dec;
   wire       is_static;

   // top bit picks single or multi
   // port code table, 011 flagged reserved with no port
   assign port_dec        = lewuw_port_dec(i_upper[`LEWUW_F_PORT_HI:`LEWUW_F_PORT_LO]);
   assign o_port_mask     = port_dec[2:0];
   assign o_port_reserved = port_dec[3];

   assign o_prio_apply = i_upper[`LEWUW_F_PRIO_EN] & i_dest_prio_sel;
   assign o_prio       = o_prio_apply ? i_upper[`LEWUW_F_PRIO_HI:`LEWUW_F_PRIO_LO] : 3'h0;

   assign o_drop = i_upper[`LEWUW_F_FILTER];

   assign is_static = i_upper[`LEWUW_F_STATIC];
   assign o_override = is_static & i_upper[`LEWUW_F_AGE];
   // static locks out aging and learning
   assign o_learn_lock = is_static;
   assign o_ageable = ~is_static;

   assign o_valid = i_upper[`LEWUW_F_VALID];

endmodule

// >>> hdl/lewuw_top.v
// Lookup entry staging words, insert command and commit port toward the lookup table
`timescale 1ns/1ps
`include "lewuw_defines.vh"

// Notes on behaviour
// - Commit with valid flag set marks the written table entry valid.
// - Commit with valid clear invalidates any entry holding the same address.
// - Static entry with aging flag forwards regardless of port state, except disabled.
// - Static entries are never aged out nor changed by learning.
// - Non-static entries age out after five to ten idle minutes.
// - Filter flag drops packets whose destination matches the entry.
// - Priority enable decides whether the priority field is used.
// - Priority applies only with entry enable and global destination priority select.
// - Port field top bit zero selects one port, one selects several.
// - Port codes: 0,1,2 single; 011 reserved; 100..111 port pairs and all.
// - Low sixteen bits carry the last sixteen address bits.
// - Software loads staging words first; commit happens only on insert command.
// - Insert bit commits both words; software clears it after pending drops.
// - Lower word carries the first 32 address bits, bit 0 multicast.

module lewuw_top (
   input  wire        i_clock,
   input  wire        i_rst,
   input  wire [15:0] i_reg_addr,
   input  wire        i_reg_wr,
   input  wire [31:0] i_reg_wdata,
   input  wire        i_reg_rd,
   input  wire        i_dest_prio_sel,
   input  wire        i_table_done,
   output reg  [31:0] o_reg_rdata,
   output reg         o_reg_rvalid,
   output reg         o_commit,
   output reg  [47:0] o_commit_mac,
   output reg         o_commit_valid,
   output reg  [2:0]  o_commit_port_mask,
   output reg         o_commit_port_reserved,
   output reg         o_commit_prio_apply,
   output reg  [2:0]  o_commit_prio,
   output reg         o_commit_drop,
   output reg         o_commit_override,
   output reg         o_commit_ageable,
   output reg         o_commit_learn_lock,
   output reg         o_pending
);

   // ==========================================================
   // Staging and command state
   reg  [31:0] upper_q;
   reg  [31:0] lower_q;
   reg         make_q;
   reg         pending_q;

   wire        wr_cmd;
   wire        wr_lower;
   wire        wr_upper;
   wire        start;
   reg  [31:0] rdata_d;

   wire [2:0]  dec_port_mask;
   wire        dec_port_reserved;
   wire        dec_prio_apply;
   wire [2:0]  dec_prio;
   wire        dec_drop;
   wire        dec_override;
   wire        dec_ageable;
   wire        dec_learn_lock;
   wire        dec_valid;

   assign wr_cmd   = i_reg_wr & (i_reg_addr == `LEWUW_IDX_CMD);
   assign wr_lower = i_reg_wr & (i_reg_addr == `LEWUW_IDX_LOWER);
   assign wr_upper = i_reg_wr & (i_reg_addr == `LEWUW_IDX_UPPER);

   // commit only on insert command
   // Rising edge only, so a held bit does not re-commit
   assign start = wr_cmd & i_reg_wdata[`LEWUW_CMD_MAKE_BIT] & ~make_q & ~pending_q;

   // ==========================================================
   // Register writes
   always @(posedge i_clock) begin
      if (i_rst) begin
         upper_q <= `LEWUW_UPPER_RST;
         lower_q <= `LEWUW_LOWER_RST;
         make_q  <= 1'b0;
      end else begin
         if (wr_upper) begin
            upper_q <= i_reg_wdata & `LEWUW_UPPER_WR_MASK;
         end
         if (wr_lower) begin
            lower_q <= i_reg_wdata;
         end
         if (wr_cmd) begin
            make_q <= i_reg_wdata[`LEWUW_CMD_MAKE_BIT];
         end
      end
   end

   // ==========================================================
   // Pending indication
   always @(posedge i_clock) begin
      if (i_rst) begin
         pending_q <= 1'b0;
         o_pending <= 1'b0;
      end else begin
         // pending until table reports done; set wins
         if (start) begin
            pending_q <= 1'b1;
            o_pending <= 1'b1;
         end else if (i_table_done) begin
            pending_q <= 1'b0;
            o_pending <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Field decode
   lewuw_decode u_decode (
      .i_upper         (upper_q),
      .i_dest_prio_sel (i_dest_prio_sel),
      .o_port_mask     (dec_port_mask),
      .o_port_reserved (dec_port_reserved),
      .o_prio_apply    (dec_prio_apply),
      .o_prio          (dec_prio),
      .o_drop          (dec_drop),
      .o_override      (dec_override),
      .o_ageable       (dec_ageable),
      .o_learn_lock    (dec_learn_lock),
      .o_valid         (dec_valid)
   );

   // ==========================================================
   // Commit toward the table
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_commit               <= 1'b0;
         o_commit_mac           <= 48'h000000000000;
         o_commit_valid         <= 1'b0;
         o_commit_port_mask     <= 3'h0;
         o_commit_port_reserved <= 1'b0;
         o_commit_prio_apply    <= 1'b0;
         o_commit_prio          <= 3'h0;
         o_commit_drop          <= 1'b0;
         o_commit_override      <= 1'b0;
         o_commit_ageable       <= 1'b0;
         o_commit_learn_lock    <= 1'b0;
      end else begin
         o_commit <= start;
         // Fields held stable after commit for the table engine
         if (start) begin
            o_commit_mac           <= {upper_q[`LEWUW_F_MAC_HI:`LEWUW_F_MAC_LO], lower_q};
            o_commit_valid         <= dec_valid;
            o_commit_port_mask     <= dec_port_mask;
            o_commit_port_reserved <= dec_port_reserved;
            o_commit_prio_apply    <= dec_prio_apply;
            o_commit_prio          <= dec_prio;
            o_commit_drop          <= dec_drop;
            o_commit_override      <= dec_override;
            o_commit_ageable       <= dec_ageable;
            o_commit_learn_lock    <= dec_learn_lock;
         end
      end
   end

   // ==========================================================
   // Register reads, unmapped index reads zero
   always @* begin
      rdata_d = 32'h00000000;
      case (i_reg_addr)
         `LEWUW_IDX_CMD:     rdata_d[`LEWUW_CMD_MAKE_BIT] = make_q;
         `LEWUW_IDX_LOWER:   rdata_d = lower_q;
         `LEWUW_IDX_UPPER:   rdata_d = upper_q & `LEWUW_UPPER_WR_MASK;
         `LEWUW_IDX_CMD_STS: rdata_d[`LEWUW_STS_PEND_BIT] = pending_q;
         default:            rdata_d = 32'h00000000;
      endcase
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         o_reg_rdata  <= 32'h00000000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end

endmodule

// >>> verification/lewuw_chk.sv
// Checker for the lookup entry staging words and insert command
`timescale 1ns/1ps
`include "lewuw_defines.vh"

module lewuw_chk (
   input wire        i_clock,
   input wire        i_rst,
   input wire [15:0] i_reg_addr,
   input wire        i_reg_wr,
   input wire [31:0] i_reg_wdata,
   input wire        i_dest_prio_sel,
   input wire        i_table_done,
   input wire        o_commit,
   input wire [2:0]  o_commit_port_mask,
   input wire        o_commit_port_reserved,
   input wire        o_commit_prio_apply,
   input wire [2:0]  o_commit_prio,
   input wire        o_commit_override,
   input wire        o_commit_ageable,
   input wire        o_commit_learn_lock,
   input wire        o_pending
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ==========================================================
   // Steps of an insert
   sequence s_insert_wr;
      i_reg_wr && i_reg_addr == `LEWUW_IDX_CMD && i_reg_wdata[2] && !o_pending;
   endsequence
   sequence s_finish;
      o_pending && i_table_done;
   endsequence
   a_commit_cause: assert property (o_commit |-> $past(i_reg_wr && i_reg_addr == `LEWUW_IDX_CMD
      && i_reg_wdata[2] && !o_pending)) else $error("commit without insert write");
   a_insert_pend: assert property (s_insert_wr ##1 o_commit |-> o_pending)
      else $error("pending not raised");
   a_done_clear: assert property (s_finish |=> !o_pending) else $error("pending not cleared");
   a_pend_hold: assert property (o_pending && !i_table_done |=> o_pending)
      else $error("pending dropped early");
   a_port_resv: assert property (o_commit |-> o_commit_port_reserved == (o_commit_port_mask == 3'h0))
      else $error("reserved port code mismatch");
   a_prio_gate: assert property (o_commit && !o_commit_prio_apply |-> o_commit_prio == 3'h0)
      else $error("priority used while off");
   a_prio_sel: assert property (o_commit && o_commit_prio_apply |-> $past(i_dest_prio_sel))
      else $error("priority without global select");
   a_static_age: assert property (o_commit |-> o_commit_ageable != o_commit_learn_lock)
      else $error("static and ageable clash");
   a_override_static: assert property (o_commit && o_commit_override |-> o_commit_learn_lock)
      else $error("override without static");
endmodule

bind lewuw_top lewuw_chk u_chk (.i_clock, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_dest_prio_sel,
   .i_table_done, .o_commit, .o_commit_port_mask, .o_commit_port_reserved, .o_commit_prio_apply,
   .o_commit_prio, .o_commit_override, .o_commit_ageable, .o_commit_learn_lock, .o_pending);

// >>> verification/lookup_entry_write_upper_word_bench.sv
// Self-checking bench for the lookup entry staging words
`timescale 1ns/1ps
`include "lewuw_defines.vh"

module lookup_entry_write_upper_word_bench;
   reg         i_clock = 1'b0;
   reg         i_rst = 1'b1;
   reg  [15:0] i_reg_addr = 16'h0000;
   reg         i_reg_wr = 1'b0;
   reg  [31:0] i_reg_wdata = 32'h00000000;
   reg         i_reg_rd = 1'b0;
   reg         i_dest_prio_sel = 1'b0;
   reg         i_table_done = 1'b0;
   wire [31:0] rdata;
   wire [47:0] mac;
   wire [2:0]  pmask, prio;
   wire        rvalid, commit, cvalid, presv, papply, drop, ovr, ageable, lock, pending;
   integer     errors = 0;
   integer     compares = 0;
   integer     c;
   reg  [31:0] rd_q;
   // Expected port mask per code, code 0 in the low bits
   localparam [23:0] MASKS = {3'h7, 3'h6, 3'h5, 3'h3, 3'h0, 3'h4, 3'h2, 3'h1};

   always #10 i_clock = ~i_clock;

   lewuw_top dut (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .i_dest_prio_sel(i_dest_prio_sel),
      .i_table_done(i_table_done), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_commit(commit),
      .o_commit_mac(mac), .o_commit_valid(cvalid), .o_commit_port_mask(pmask),
      .o_commit_port_reserved(presv), .o_commit_prio_apply(papply), .o_commit_prio(prio),
      .o_commit_drop(drop), .o_commit_override(ovr), .o_commit_ageable(ageable),
      .o_commit_learn_lock(lock), .o_pending(pending));

   // ==========================================================
   // Bus and compare tasks
   task chk(input [63:0] seen, input [63:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input [15:0] a, input [31:0] d);
      @(negedge i_clock); i_reg_addr = a; i_reg_wdata = d; i_reg_wr = 1'b1;
      @(negedge i_clock); i_reg_wr = 1'b0;
   endtask
   task rd(input [15:0] a);
      @(negedge i_clock); i_reg_addr = a; i_reg_rd = 1'b1;
      @(negedge i_clock); i_reg_rd = 1'b0;
      chk(rvalid, 1'b1);
      rd_q = rdata;
   endtask
   task finish_cmd;
      @(negedge i_clock); i_table_done = 1'b1;
      @(negedge i_clock); i_table_done = 1'b0;
      chk(pending, 1'b0);
      wr(`LEWUW_IDX_CMD, 32'h00000000);
   endtask
   // Stage both words and insert; fields stay held after the return
   task ins(input [31:0] up, input [31:0] lo, input sel);
      wr(`LEWUW_IDX_LOWER, lo);
      wr(`LEWUW_IDX_UPPER, up);
      i_dest_prio_sel = sel;
      chk(commit, 1'b0);
      wr(`LEWUW_IDX_CMD, 32'h00000004);
      chk({commit, pending}, 2'b11);
      finish_cmd;
   endtask

   // ==========================================================
   // Scenarios
   task t_regs;
      rd(`LEWUW_IDX_UPPER); chk(rd_q, 32'h00000000);
      rd(`LEWUW_IDX_CMD); chk(rd_q, 32'h00000000);
      rd(16'h1803); chk(rd_q, 32'h00000000);
      wr(`LEWUW_IDX_UPPER, 32'hFFFFFFFF);
      rd(`LEWUW_IDX_UPPER); chk(rd_q, 32'h07FFFFFF);
      wr(`LEWUW_IDX_LOWER, 32'hFFFFFFFF);
      rd(`LEWUW_IDX_LOWER); chk(rd_q, 32'hFFFFFFFF);
      $display("test regs done");
   endtask
   task t_ports;
      for (c = 0; c < 8; c = c + 1) begin
         ins((c % 2) << 26 | c << 16 | (32'h5A30 + c), 32'h13579BDF ^ c, 1'b0);
         chk(pmask, MASKS[c*3 +: 3]);
         chk(presv, c == 3);
         chk(cvalid, c % 2);
         chk(mac, {16'h5A30 + c[15:0], 32'h13579BDF ^ c});
         chk({ageable, lock}, 2'b10);
      end
      $display("test ports done");
   endtask
   task t_flags;
      ins(32'h03E80000, 32'h00000001, 1'b1);
      chk({cvalid, ovr, drop, papply, prio, lock}, 8'h7B);
      ins(32'h03E80000, 32'h00000001, 1'b0);
      chk({papply, prio}, 4'h0);
      ins(32'h02000000, 32'h00000002, 1'b1);
      chk({ovr, ageable, papply}, 3'h2);
      $display("test flags done");
   endtask
   task t_refuse;
      wr(`LEWUW_IDX_CMD, 32'h00000004);
      rd(`LEWUW_IDX_CMD_STS); chk(rd_q, 32'h00000001);
      wr(`LEWUW_IDX_CMD, 32'h00000000);
      wr(`LEWUW_IDX_CMD, 32'h00000004);
      chk(commit, 1'b0);
      @(negedge i_clock); i_table_done = 1'b1;
      @(negedge i_clock); i_table_done = 1'b0;
      wr(`LEWUW_IDX_CMD, 32'h00000004);
      chk(commit, 1'b0);
      wr(`LEWUW_IDX_CMD, 32'h00000000);
      wr(`LEWUW_IDX_CMD, 32'h00000004);
      chk(commit, 1'b1);
      finish_cmd;
      $display("test refuse done");
   endtask

   task close_out;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (8) @(negedge i_clock);
      i_rst = 1'b0;
      t_regs;
      t_ports;
      t_flags;
      t_refuse;
      close_out;
   end
   // Hang guard, far beyond the roughly 150 cycles of the tests
   initial begin
      #200000;
      errors = errors + 1;
      close_out;
   end
endmodule
